/* File: test/cagd_core_assertions.sv */
`timescale 1ns/1ns
module cagd_core_assertions
	import cagd_pkg::*;
(
	input wire logic        clk_ref,
	input wire logic        rst_n,
	input wire logic        op_valid,
	input wire cagd_amode_t amode,
	input wire logic        word_sz,
	input wire logic        long_field,
	input wire logic        step_down,
	input wire logic        stack_push,
	input wire logic        stack_pop,
	input wire logic        load_stack,
	input wire logic        jump,
	input wire logic        fetch_adv,
	input wire logic [15:0] field,
	input wire logic [15:0] first_pointer,
	input wire logic [15:0] limit_reg,
	input wire logic [15:0] sum_reg,
	input wire logic [15:0] stack_top,
	input wire logic [15:0] fetch_pointer,
	input wire logic [15:0] operand_addr,
	input wire logic        skip_pending,
	input wire logic        op_done
);
	default clocking @(posedge clk_ref); endclocking
	default disable iff (!rst_n);
	sequence s_go; op_valid && !skip_pending; endsequence
	chk_done_pulse: assert property (op_valid |=> op_done) else $error("no done");
	chk_push_step: assert property (s_go ##0 (stack_push && !load_stack) |=>
		stack_top == $past(stack_top) + 16'h0002) else $error("push step");
	chk_pop_step: assert property (s_go ##0 (stack_pop && !stack_push && !load_stack) |=>
		stack_top == $past(stack_top) - 16'h0002) else $error("pop step");
	chk_fetch_step: assert property (op_valid && fetch_adv && !jump |=>
		fetch_pointer == $past(fetch_pointer) + 16'h0001) else $error("fetch step");
	chk_skip_quiet: assert property (op_valid && skip_pending |=> !skip_pending &&
		$stable(sum_reg) && $stable(first_pointer) && $stable(limit_reg) && $stable(stack_top))
		else $error("skip changed state");
	chk_direct_addr: assert property (s_go ##0 (amode == CAGD_AM_DIRECT && long_field &&
		!word_sz) |=> operand_addr == $past(field)) else $error("direct addr");
	chk_word_even: assert property (s_go ##0 word_sz |=> !operand_addr[0]) else $error("odd");
	chk_skip_raise: assert property (s_go ##0 (amode == CAGD_AM_SKIP && !step_down) |=>
		skip_pending == (first_pointer > limit_reg)) else $error("skip raise");
endmodule : cagd_core_assertions
////////////////////////////////////////////////////////////////////////
bind cagd_core cagd_core_assertions u_cagd_core_assertions (.clk_ref(clk_ref), .rst_n(rst_n),
	.op_valid(op_valid), .amode(amode), .word_sz(word_sz), .long_field(long_field),
	.step_down(step_down), .stack_push(stack_push), .stack_pop(stack_pop),
	.load_stack(load_stack), .jump(jump), .fetch_adv(fetch_adv), .field(field),
	.first_pointer(first_pointer), .limit_reg(limit_reg), .sum_reg(sum_reg),
	.stack_top(stack_top), .fetch_pointer(fetch_pointer), .operand_addr(operand_addr),
	.skip_pending(skip_pending), .op_done(op_done));

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import cagd_pkg::*;
	localparam logic [14:0] WS = 15'h4000, LG = 15'h2000, US = 15'h1000, SD = 15'h0800;
	localparam logic [14:0] WR = 15'h0200, WC = 15'h0100, LF = 15'h0080, L2 = 15'h0040;
	localparam logic [14:0] LK = 15'h0020, LT = 15'h0010, PU = 15'h0008, PO = 15'h0004;
	localparam logic [14:0] JP = 15'h0002, AD = 15'h0001, CY = 15'h0400;
	logic         clk_ref  = 1'b0;
	logic         rst_n    = 1'b0;
	logic         op_valid = 1'b0;
	cagd_alu_op_t alu_op   = CAGD_ALU_ADD;
	cagd_amode_t  amode    = CAGD_AM_IMMED;
	logic [14:0]  ctl      = 15'h0000;
	logic [15:0]  field    = 16'h0000;
	logic [15:0]  disp     = 16'h0000;
	logic [15:0]  mem_word = 16'h0000;
	logic [15:0]  mem_data = 16'h5A5A;
	logic [15:0]  mw       = 16'h0000;
	logic [15:0]  dp       = 16'h0000;
	logic [15:0]  sum_reg, first_pointer, second_pointer, limit_reg;
	logic [15:0]  stack_top, fetch_pointer, operand_addr, operand_val;
	logic         flag_out, skip_pending, op_done;
	int           check_count = 0;
	int           fail_count  = 0;
	cagd_core u_cagd_core (
		.clk_ref(clk_ref), .rst_n(rst_n), .op_valid(op_valid), .alu_op(alu_op),
		.amode(amode), .word_sz(ctl[14]), .long_field(ctl[13]), .use_second(ctl[12]),
		.step_down(ctl[11]), .use_carry(ctl[10]), .write_sum(ctl[9]), .write_carry(ctl[8]),
		.load_first(ctl[7]), .load_second(ctl[6]), .load_limit(ctl[5]), .load_stack(ctl[4]),
		.stack_push(ctl[3]), .stack_pop(ctl[2]), .jump(ctl[1]), .fetch_adv(ctl[0]),
		.field(field), .disp(disp), .mem_word(mem_word), .mem_data(mem_data),
		.sum_reg(sum_reg), .flag_out(flag_out), .first_pointer(first_pointer),
		.second_pointer(second_pointer), .limit_reg(limit_reg), .stack_top(stack_top),
		.fetch_pointer(fetch_pointer), .operand_addr(operand_addr),
		.operand_val(operand_val), .skip_pending(skip_pending), .op_done(op_done));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic op(input cagd_amode_t m, input cagd_alu_op_t o, input logic [15:0] f,
		input logic [14:0] c);
		@(posedge clk_ref);
		op_valid <= 1'b1;
		amode <= m;
		alu_op <= o;
		field <= f;
		ctl <= c;
		mem_word <= mw;
		disp <= dp;
		@(posedge clk_ref);
		op_valid <= 1'b0;
		ctl <= 15'h0000;
		@(negedge clk_ref);
		chk(op_done, 16'h0001);
	endtask : op
	task automatic ld(input logic [15:0] v, input logic [14:0] c);
		op(CAGD_AM_IMMED, CAGD_ALU_ADD, v, c | LG);
	endtask : ld
	task automatic alu(input cagd_alu_op_t o, input logic [15:0] v, input logic [15:0] e,
		input logic c);
		ld(v, 15'h0000);
		op(CAGD_AM_IMMED, o, v, WR | WC | LG);
		chk(sum_reg, e);
		chk(flag_out, c);
	endtask : alu
	task automatic t_reset();
		@(negedge clk_ref);
		chk(sum_reg, 16'h0000);
		chk(stack_top, 16'h0000);
		chk(fetch_pointer, 16'h0000);
	endtask : t_reset
	task automatic t_alu();
		alu(CAGD_ALU_ADD, 16'h1234, 16'h1234, 1'b0);
		chk(operand_val, 16'h1234);
		alu(CAGD_ALU_ADD, 16'hFFFF, 16'h1233, 1'b1);
		alu(CAGD_ALU_XOR, 16'h00FF, 16'h12CC, 1'b0);
		alu(CAGD_ALU_AND, 16'h0FF0, 16'h02C0, 1'b0);
		alu(CAGD_ALU_OR, 16'hF000, 16'hF2C0, 1'b0);
		alu(CAGD_ALU_SHL, 16'h0000, 16'hE580, 1'b1);
		alu(CAGD_ALU_SHR, 16'h0000, 16'h72C0, 1'b0);
		alu(CAGD_ALU_SUB, 16'h02C0, 16'h7000, 1'b1);
		op(CAGD_AM_IMMED, CAGD_ALU_ADD, 16'hAB01, WR);
		chk(sum_reg, 16'h7001);
		op(CAGD_AM_IMMED, CAGD_ALU_ADD, 16'h0001, WR | WC | CY);
		chk(sum_reg, 16'h7003);
		chk(flag_out, 16'h0000);
		op(CAGD_AM_IMMED, CAGD_ALU_SUB, 16'h0003, WR | WC | CY);
		chk(sum_reg, 16'h6FFF);
		chk(flag_out, 16'h0001);
	endtask : t_alu
	task automatic t_stack();
		ld(16'h0101, LT);
		chk(stack_top, 16'h0100);
		ld(16'h0000, PU);
		ld(16'h0000, PU);
		chk(stack_top, 16'h0104);
		ld(16'h0000, PO);
		chk(stack_top, 16'h0102);
	endtask : t_stack
	task automatic t_addr();
		ld(16'h0004, LF);
		ld(16'h0300, L2);
		op(CAGD_AM_DIRECT, CAGD_ALU_PASS, 16'h12AB, 15'h0000);
		chk(operand_addr, 16'h00AB);
		op(CAGD_AM_DIRECT, CAGD_ALU_PASS, 16'h1235, WS | LG);
		chk(operand_addr, 16'h1234);
		op(CAGD_AM_DIRECT, CAGD_ALU_PASS, 16'h1235, LG);
		chk(operand_addr, 16'h1235);
		mw = 16'h2000;
		dp = 16'h3410;
		op(CAGD_AM_INDIRECT, CAGD_ALU_PASS, 16'h0040, WS);
		chk(operand_addr, 16'h2000);
		op(CAGD_AM_INDEXED, CAGD_ALU_PASS, 16'h0040, WS);
		chk(operand_addr, 16'h2010);
		op(CAGD_AM_INDEXED, CAGD_ALU_PASS, 16'h0040, WS | LG);
		chk(operand_addr, 16'h5410);
		op(CAGD_AM_REG_IND, CAGD_ALU_PASS, 16'h0000, 15'h0000);
		chk(operand_addr, 16'h0004);
		op(CAGD_AM_REG_IND, CAGD_ALU_PASS, 16'h0000, US);
		chk(operand_addr, 16'h0300);
		op(CAGD_AM_AUTO, CAGD_ALU_PASS, 16'h0000, WS);
		chk(operand_addr, 16'h0300);
		chk(second_pointer, 16'h0302);
		op(CAGD_AM_AUTO, CAGD_ALU_PASS, 16'h0000, SD);
		chk(operand_addr, 16'h0302);
		chk(second_pointer, 16'h0301);
	endtask : t_addr
	task automatic t_fetch();
		ld(16'h0400, JP);
		ld(16'h0000, AD);
		ld(16'h0000, AD);
		chk(fetch_pointer, 16'h0402);
	endtask : t_fetch
	task automatic t_skip();
		ld(16'h0005, LK);
		ld(16'h0004, LF);
		op(CAGD_AM_SKIP, CAGD_ALU_PASS, 16'h0000, 15'h0000);
		chk(skip_pending, 16'h0000);
		op(CAGD_AM_SKIP, CAGD_ALU_PASS, 16'h0000, 15'h0000);
		chk(first_pointer, 16'h0006);
		chk(skip_pending, 16'h0001);
		op(CAGD_AM_IMMED, CAGD_ALU_ADD, 16'h7777, LG | LK | LF | WR | JP | AD);
		chk(limit_reg, 16'h0005);
		chk(sum_reg, 16'h6FFF);
		chk(skip_pending, 16'h0000);
		chk(fetch_pointer, 16'h0403);
	endtask : t_skip
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	initial begin
		forever #50 clk_ref = ~clk_ref;
	end
	initial begin
		repeat (3) @(posedge clk_ref);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_ref);
		t_reset();
		t_alu();
		t_stack();
		t_addr();
		t_fetch();
		t_skip();
		give_verdict();
	end
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
endmodule : testbench

/* File: verilog/cagd_agen.sv */
`timescale 1ns/1ns
module cagd_agen
	import cagd_pkg::*;
(
	input  wire cagd_amode_t amode,
	input  wire logic        word_sz,
	input  wire logic        step_down,
	input  wire logic        long_field,
	input  wire logic [15:0] field,
	input  wire logic [15:0] disp,
	input  wire logic [15:0] mem_word,
	input  wire logic [15:0] first_ptr,
	input  wire logic [15:0] second_ptr,
	input  wire logic        use_second,
	output logic      [15:0] addr,
	output logic      [15:0] step
);
	logic [15:0] fld;

	always_comb begin
		fld  = long_field ? field : {8'h00, field[7:0]};
		step = word_sz ? WORD_STEP : BYTE_STEP;
		if (step_down) begin
			step = 16'(~step + 16'h0001);
		end
		unique case (amode)
			CAGD_AM_REG_IND:  addr = use_second ? second_ptr : first_ptr;
			CAGD_AM_DIRECT:   addr = fld;
			CAGD_AM_INDIRECT: addr = mem_word;
			CAGD_AM_INDEXED:  addr = 16'(mem_word + (long_field ? disp : {8'h00, disp[7:0]}));
			CAGD_AM_AUTO:     addr = second_ptr;
			CAGD_AM_SKIP:     addr = first_ptr;
			default:          addr = fld;
		endcase
		if (word_sz) begin
			addr = addr & EVEN_MASK;
		end
	end

endmodule : cagd_agen

/* File: verilog/cagd_alu.sv */
`timescale 1ns/1ns
module cagd_alu
	import cagd_pkg::*;
(
	cagd_alu_if.unit a
);
	logic [16:0] wide;

	// One combinational pass per operation, so it fits a single cycle.
	always_comb begin
		wide = 17'h00000;
		unique case (a.op)
			CAGD_ALU_ADD:  wide = {1'b0, a.opa} + {1'b0, a.opb} + {16'h0000, a.cin};
			CAGD_ALU_SUB:  wide = {1'b0, a.opa} - {1'b0, a.opb} - {16'h0000, ~a.cin};
			CAGD_ALU_SHL:  wide = {a.opa, 1'b0};
			CAGD_ALU_SHR:  wide = {a.opa[0], 1'b0, a.opa[15:1]};
			CAGD_ALU_AND:  wide = {1'b0, a.opa & a.opb};
			CAGD_ALU_OR:   wide = {1'b0, a.opa | a.opb};
			CAGD_ALU_XOR:  wide = {1'b0, a.opa ^ a.opb};
			CAGD_ALU_PASS: wide = {1'b0, a.opb};
		endcase
		a.res  = wide[15:0];
		a.cout = (a.op == CAGD_ALU_SUB) ? ~wide[16] : wide[16];
	end

endmodule : cagd_alu

/* File: verilog/cagd_alu_if.sv */
`timescale 1ns/1ns
interface cagd_alu_if;
	import cagd_pkg::*;
	logic [15:0]  opa;
	logic [15:0]  opb;
	logic         cin;
	cagd_alu_op_t op;
	logic [15:0]  res;
	logic         cout;
	modport user (output opa, output opb, output cin, output op, input res, input cout);
	modport unit (input opa, input opb, input cin, input op, output res, output cout);
endinterface : cagd_alu_if

/* File: verilog/cagd_core.sv */
`timescale 1ns/1ns
// What this block does
// - Sixteen-bit ALU, any operation in one cycle.
// - ALU carry lands in one-bit flag.
// - Accumulator is main source and destination.
// - Two pointers address operands and step.
// - Limit register bounds pointer-driven loops.
// - Push raises stack by two.
// - Pop lowers stack by two.
// - Stack may sit at any even address in memory.
// - Fetch pointer addresses program memory.
// - Register indirect uses first or second pointer.
// - Direct mode uses field as address.
// - Indirect mode uses addressed word as address.
// - Indexed adds displacement to addressed word.
// - Immediate mode uses field as operand.
// - Auto mode uses second pointer, then steps.
// - Skip mode steps first pointer, compares limit.
// - Words at even addresses; byte program addressing.
module cagd_core
	import cagd_pkg::*;
(
	input  wire logic         clk_ref,
	input  wire logic         rst_n,
	input  wire logic         op_valid,
	input  wire cagd_alu_op_t alu_op,
	input  wire cagd_amode_t  amode,
	input  wire logic         word_sz,
	input  wire logic         long_field,
	input  wire logic         use_second,
	input  wire logic         step_down,
	input  wire logic         use_carry,
	input  wire logic         write_sum,
	input  wire logic         write_carry,
	input  wire logic         load_first,
	input  wire logic         load_second,
	input  wire logic         load_limit,
	input  wire logic         load_stack,
	input  wire logic         stack_push,
	input  wire logic         stack_pop,
	input  wire logic         jump,
	input  wire logic         fetch_adv,
	input  wire logic [15:0]  field,
	input  wire logic [15:0]  disp,
	input  wire logic [15:0]  mem_word,
	input  wire logic [15:0]  mem_data,
	output logic      [15:0]  sum_reg,
	output logic              flag_out,
	output logic      [15:0]  first_pointer,
	output logic      [15:0]  second_pointer,
	output logic      [15:0]  limit_reg,
	output logic      [15:0]  stack_top,
	output logic      [15:0]  fetch_pointer,
	output logic      [15:0]  operand_addr,
	output logic      [15:0]  operand_val,
	output logic              skip_pending,
	output logic              op_done
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release, then the ALU and address generator.

	logic [1:0] rst_sync_q;
	logic       rst_core_n;

	always_ff @(posedge clk_ref or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_q[1];

	cagd_alu_if alu_bus ();

	cagd_alu u_alu (
		.a (alu_bus.unit)
	);

	logic [15:0] agen_addr;
	logic [15:0] agen_step;

	cagd_agen u_agen (
		.amode      (amode),
		.word_sz    (word_sz),
		.step_down  (step_down),
		.long_field (long_field),
		.field      (field),
		.disp       (disp),
		.mem_word   (mem_word),
		.first_ptr  (first_pointer),
		.second_ptr (second_pointer),
		.use_second (use_second),
		.addr       (agen_addr),
		.step       (agen_step)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State record.

	typedef struct packed {
		logic [15:0] sum;
		logic        carry;
		logic [15:0] first;
		logic [15:0] second;
		logic [15:0] limit;
		logic [15:0] stack;
		logic [15:0] fetch;
		logic [15:0] oaddr;
		logic [15:0] oval;
		logic        skip;
		logic        done;
	} cagd_core_t;

	cagd_core_t  st_q;
	cagd_core_t  st_d;
	logic [15:0] operand;
	logic [15:0] stepped_first;
	logic        past_limit;
	logic        take_op;
	logic        drop_op;
	logic        is_immed;
	logic        is_auto;
	logic        is_skip;
	logic [15:0] sum_next;
	logic        carry_next;
	logic [15:0] first_next;
	logic [15:0] second_next;
	logic [15:0] limit_next;
	logic [15:0] stack_next;
	logic [15:0] fetch_next;
	logic        skip_next;
	logic [15:0] oaddr_next;
	logic [15:0] oval_next;

	// Every field of the state record clears to its idle value.
	localparam cagd_core_t CORE_RESET = '{
		sum:    RESET_WORD,
		carry:  1'b0,
		first:  RESET_WORD,
		second: RESET_WORD,
		limit:  RESET_WORD,
		stack:  RESET_WORD,
		fetch:  RESET_FETCH,
		oaddr:  RESET_WORD,
		oval:   RESET_WORD,
		skip:   1'b0,
		done:   1'b0
	};

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// An eight-bit field or displacement is its low byte, zero extended.
	function automatic logic [15:0] widen_field(input logic [15:0] raw, input logic is_long);
		logic [15:0] v;
		v = is_long ? raw : {8'h00, raw[7:0]};
		return v;
	endfunction : widen_field

	// The compare is strict, so a pointer that lands on the limit is not past it.
	function automatic logic beyond_limit(input logic [15:0] ptr, input logic [15:0] lim,
		input logic down);
		logic r;
		r = down ? (ptr < lim) : (ptr > lim);
		return r;
	endfunction : beyond_limit

	// Subtract reads the flag as not-borrow, and starts with no borrow unless chained.
	function automatic logic carry_in(input cagd_alu_op_t op, input logic chain,
		input logic flag);
		logic c;
		c = chain & flag;
		if (op == CAGD_ALU_SUB && !chain) begin
			c = 1'b1;
		end
		return c;
	endfunction : carry_in

	////////////////////////////////////////////////////////////////////////////////
	// Instruction decode.

	// An instruction that arrives while a skip is pending is dropped, except for its fetch step.
	always_comb begin
		drop_op  = op_valid & st_q.skip;
		take_op  = op_valid & ~st_q.skip;
		is_immed = (amode == CAGD_AM_IMMED);
		is_auto  = (amode == CAGD_AM_AUTO);
		is_skip  = (amode == CAGD_AM_SKIP);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand selection and ALU feed.

	always_comb begin
		operand = is_immed ? widen_field(field, long_field) : mem_data;
	end

	always_comb begin
		alu_bus.opa = st_q.sum;
		alu_bus.opb = operand;
		alu_bus.cin = carry_in(alu_op, use_carry, st_q.carry);
		alu_bus.op  = alu_op;
	end

	// The pointer is stepped first, and the stepped value is compared.
	always_comb begin
		stepped_first = 16'(st_q.first + agen_step);
		past_limit    = beyond_limit(stepped_first, st_q.limit, step_down);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator and carry flag.

	always_comb begin
		sum_next   = st_q.sum;
		carry_next = st_q.carry;
		if (take_op && write_sum) begin
			sum_next = alu_bus.res;
		end
		if (take_op && write_carry) begin
			carry_next = alu_bus.cout;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pointers and limit.

	// A load in the same instruction wins over the automatic step.
	always_comb begin
		first_next  = st_q.first;
		second_next = st_q.second;
		limit_next  = st_q.limit;
		if (take_op && is_auto) begin
			second_next = 16'(st_q.second + agen_step);
		end
		if (take_op && is_skip) begin
			first_next = stepped_first;
		end
		if (take_op && load_first) begin
			first_next = operand;
		end
		if (take_op && load_second) begin
			second_next = operand;
		end
		if (take_op && load_limit) begin
			limit_next = operand;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pending skip.

	// A skip raised now suppresses the next instruction, which only clears it and takes its fetch step.
	always_comb begin
		skip_next = st_q.skip;
		if (drop_op) begin
			skip_next = 1'b0;
		end else if (take_op && is_skip) begin
			skip_next = past_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stack top.

	// A load wins over a push, and a push wins over a pop.
	always_comb begin
		stack_next = st_q.stack;
		if (take_op) begin
			if (load_stack) begin
				stack_next = operand & EVEN_MASK;
			end else if (stack_push) begin
				stack_next = 16'(st_q.stack + STACK_STEP);
			end else if (stack_pop) begin
				stack_next = 16'(st_q.stack - STACK_STEP);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fetch pointer.

	// A jump in a dropped instruction is ignored, but the fetch step still runs.
	always_comb begin
		fetch_next = st_q.fetch;
		if (take_op && jump) begin
			fetch_next = operand;
		end else if (fetch_adv) begin
			fetch_next = 16'(st_q.fetch + FETCH_STEP);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand record.

	// The address and value of the last taken instruction stay visible until the next.
	always_comb begin
		oaddr_next = st_q.oaddr;
		oval_next  = st_q.oval;
		if (take_op) begin
			oaddr_next = is_immed ? 16'h0000 : agen_addr;
			oval_next  = operand;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		st_d        = st_q;
		st_d.sum    = sum_next;
		st_d.carry  = carry_next;
		st_d.first  = first_next;
		st_d.second = second_next;
		st_d.limit  = limit_next;
		st_d.stack  = stack_next;
		st_d.fetch  = fetch_next;
		st_d.oaddr  = oaddr_next;
		st_d.oval   = oval_next;
		st_d.skip   = skip_next;
		st_d.done   = op_valid;
	end

	always_ff @(posedge clk_ref or negedge rst_core_n) begin
		if (!rst_core_n) begin
			st_q <= CORE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign sum_reg        = st_q.sum;
	assign flag_out       = st_q.carry;
	assign first_pointer  = st_q.first;
	assign second_pointer = st_q.second;
	assign limit_reg      = st_q.limit;
	assign stack_top      = st_q.stack;
	assign fetch_pointer  = st_q.fetch;
	assign operand_addr   = st_q.oaddr;
	assign operand_val    = st_q.oval;
	assign skip_pending   = st_q.skip;
	assign op_done        = st_q.done;

endmodule : cagd_core

/* File: verilog/cagd_pkg.sv */
package cagd_pkg;

	localparam int unsigned DATA_W        = 16;
	localparam int unsigned SHORT_W       = 8;
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	localparam logic [15:0] STACK_STEP    = 16'h0002;
	localparam logic [15:0] WORD_STEP     = 16'h0002;
	localparam logic [15:0] BYTE_STEP     = 16'h0001;
	localparam logic [15:0] EVEN_MASK     = 16'hFFFE;
	localparam logic [15:0] FETCH_STEP    = 16'h0001;
	localparam logic [15:0] RESET_FETCH   = 16'h0000;

	typedef enum logic [2:0] {
		CAGD_ALU_ADD = 3'h0,
		CAGD_ALU_SUB = 3'h1,
		CAGD_ALU_SHL = 3'h2,
		CAGD_ALU_SHR = 3'h3,
		CAGD_ALU_AND = 3'h4,
		CAGD_ALU_OR  = 3'h5,
		CAGD_ALU_XOR = 3'h6,
		CAGD_ALU_PASS = 3'h7
	} cagd_alu_op_t;

	typedef enum logic [2:0] {
		CAGD_AM_REG_IND  = 3'h0,
		CAGD_AM_DIRECT   = 3'h1,
		CAGD_AM_INDIRECT = 3'h2,
		CAGD_AM_INDEXED  = 3'h3,
		CAGD_AM_IMMED    = 3'h4,
		CAGD_AM_AUTO     = 3'h5,
		CAGD_AM_SKIP     = 3'h6
	} cagd_amode_t;

	typedef enum logic [1:0] {
		CAGD_ST_IDLE  = 2'h0,
		CAGD_ST_FETCH = 2'h1,
		CAGD_ST_EXEC  = 2'h3
	} cagd_state_t;

endpackage : cagd_pkg
